// [design/gom_ctrl_if.sv]
// interface: decoded control fields passed from the register to the selector
`timescale 1ns/1ps
interface gom_ctrl_if;
   import gom_pkg::*;
   logic [2:0] signal_select;
   logic [2:0] source_select;
   logic local_value;
   logic drive_enable;
   modport producer (output signal_select, output source_select, output local_value, output drive_enable);
   modport consumer (input signal_select, input source_select, input local_value, input drive_enable);
endinterface

// [design/gom_ctrl_reg.sv]
// module: pin 3 output control register with its plain bus port
`timescale 1ns/1ps
module gom_ctrl_reg
   import gom_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic [7:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_write,
   input wire logic bus_read,
   output logic [7:0] bus_rdata,
   gom_ctrl_if.producer ctrl
);
   logic [7:0] ctrl_r;
   logic [7:0] ctrl_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;

   // write updates the whole byte; reads answer one cycle later, others read zero
   always_comb begin
      ctrl_nxt = ctrl_r;
      rdata_nxt = READ_UNMAPPED;
      if (bus_write && bus_addr == CTRL_OFFSET) begin
         ctrl_nxt = bus_wdata;
      end
      if (bus_read && bus_addr == CTRL_OFFSET) begin
         rdata_nxt = ctrl_r;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         ctrl_r <= CTRL_RESET;
         rdata_r <= READ_UNMAPPED;
      end else begin
         ctrl_r <= ctrl_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // field split
   assign bus_rdata = rdata_r;
   assign ctrl.signal_select = ctrl_r[SEL_MSB:SEL_LSB];
   assign ctrl.source_select = ctrl_r[SRC_MSB:SRC_LSB];
   assign ctrl.local_value = ctrl_r[VAL_BIT];
   assign ctrl.drive_enable = ctrl_r[EN_BIT];
endmodule

// [design/gom_pin3_mux.sv]
// module: top of the pin 3 output multiplexer and driver control
// Notes on behaviour
// - Source field bits 4:2 pick rx port 0-3 (000-011), device status (100), reserved (101), tx 0/1 (110/111).
// - With an rx source, select 000 and 001 give that port's received remote inputs 0 and 1.
// - With an rx source, select 010 and 011 give that port's received remote inputs 2 and 3.
// - With an rx source, select 100-111 give lock, pass, frame valid and line valid of that port.
// - With device status, select 000 gives the local value bit and 001 the or of enabled ports' lock.
// - With device status, select 100 gives the frame sync pulse and 101-111 are reserved.
// - With device status, select 010 and 011 both give the and of enabled ports' pass.
// - With a tx source, 000 gives the and and 001 the or of pass over the ports that transmitter selected.
// - With a tx source, 010 gives its frame valid and 011 its line valid.
// - With a tx source, 100 gives its multi-port synchronized indication.
// - With a tx source, 101 gives that transmitter's interrupt and 110-111 are reserved.
// - Bit 1 is the pin level whenever the local value is routed out and bit 0 is set.
// - The pin is driven only while bit 0 is set; otherwise the driver is off.
`timescale 1ns/1ps
module gom_pin3_mux
   import gom_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic [7:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_write,
   input wire logic bus_read,
   output logic [7:0] bus_rdata,
   input wire logic [NUM_RX*4-1:0] rx_remote_input,
   input wire logic [NUM_RX-1:0] rx_lock,
   input wire logic [NUM_RX-1:0] rx_pass,
   input wire logic [NUM_RX-1:0] rx_frame_valid,
   input wire logic [NUM_RX-1:0] rx_line_valid,
   input wire logic [NUM_RX-1:0] rx_port_enabled,
   input wire logic frame_sync_pulse,
   input wire logic [NUM_TX*NUM_RX-1:0] tx_port_select,
   input wire logic [NUM_TX-1:0] tx_frame_valid,
   input wire logic [NUM_TX-1:0] tx_line_valid,
   input wire logic [NUM_TX-1:0] tx_synchronized,
   input wire logic [NUM_TX-1:0] tx_interrupt,
   input wire logic pin3_in,
   output logic pin3_out,
   output logic pin3_oe
);
   gom_ctrl_if ctrl_bus ();
   gom_kind_type kind;
   logic [1:0] rx_index;
   logic tx_index;
   logic [NUM_TX-1:0] tx_pass_and;
   logic [NUM_TX-1:0] tx_pass_or;
   logic dev_lock_or;
   logic dev_pass_and;
   logic level_nxt;
   logic oe_nxt;
   logic out_r;
   logic oe_r;

   gom_ctrl_reg u_reg (
      .clock(clock),
      .reset(reset),
      .bus_addr(bus_addr),
      .bus_wdata(bus_wdata),
      .bus_write(bus_write),
      .bus_read(bus_read),
      .bus_rdata(bus_rdata),
      .ctrl(ctrl_bus.producer)
   );

   gom_src_decode u_dec (
      .ctrl(ctrl_bus.consumer),
      .kind(kind),
      .rx_index(rx_index),
      .tx_index(tx_index)
   );

   // device status: only enabled ports take part; no enabled port gives or=0, and=1
   assign dev_lock_or = |(rx_lock & rx_port_enabled);
   assign dev_pass_and = &(rx_pass | ~rx_port_enabled);

   // per transmitter pass summary over its selected receive ports
   genvar t;
   generate
      for (t = 0; t < NUM_TX; t++) begin : g_tx
         assign tx_pass_and[t] = &(rx_pass | ~tx_port_select[t*NUM_RX +: NUM_RX]);
         assign tx_pass_or[t] = |(rx_pass & tx_port_select[t*NUM_RX +: NUM_RX]);
      end
   endgenerate

   // output selection; default low covers every reserved code
   always_comb begin
      level_nxt = 1'b0;
      oe_nxt = ctrl_bus.drive_enable;
      unique case (kind)
         GOM_KIND_RX: begin
            unique case (ctrl_bus.signal_select)
               SEL_0, SEL_1: level_nxt = rx_remote_input[{rx_index, ctrl_bus.signal_select[1:0]}];
               SEL_2, SEL_3: level_nxt = rx_remote_input[{rx_index, ctrl_bus.signal_select[1:0]}];
               SEL_4: level_nxt = rx_lock[rx_index];
               SEL_5: level_nxt = rx_pass[rx_index];
               SEL_6: level_nxt = rx_frame_valid[rx_index];
               SEL_7: level_nxt = rx_line_valid[rx_index];
            endcase
         end
         GOM_KIND_DEV: begin
            unique case (ctrl_bus.signal_select)
               SEL_0: level_nxt = ctrl_bus.local_value;
               SEL_1: level_nxt = dev_lock_or;
               SEL_2, SEL_3: level_nxt = dev_pass_and;
               SEL_4: level_nxt = frame_sync_pulse;
               default: level_nxt = 1'b0;
            endcase
         end
         GOM_KIND_TX: begin
            unique case (ctrl_bus.signal_select)
               SEL_0: level_nxt = tx_pass_and[tx_index];
               SEL_1: level_nxt = tx_pass_or[tx_index];
               SEL_2: level_nxt = tx_frame_valid[tx_index];
               SEL_3: level_nxt = tx_line_valid[tx_index];
               SEL_4: level_nxt = tx_synchronized[tx_index];
               SEL_5: level_nxt = tx_interrupt[tx_index];
               default: level_nxt = 1'b0;
            endcase
         end
         default: level_nxt = 1'b0;
      endcase
      // driver off means no level is presented either
      if (!ctrl_bus.drive_enable) begin
         level_nxt = 1'b0;
      end
   end

   // registered pin outputs: one cycle of latency keeps the pad glitch free
   always_ff @(posedge clock) begin
      if (reset) begin
         out_r <= 1'b0;
         oe_r <= 1'b0;
      end else begin
         out_r <= level_nxt;
         oe_r <= oe_nxt;
      end
   end

   assign pin3_out = out_r;
   assign pin3_oe = oe_r;

   // checks
   sequence s_dev_local;
      kind == GOM_KIND_DEV && ctrl_bus.signal_select == SEL_0 && ctrl_bus.drive_enable;
   endsequence

   a_src_decode: assert property (@(posedge clock) disable iff (reset)
      (ctrl_bus.source_select == SRC_RSVD) |-> kind == GOM_KIND_NONE)
      else $error("reserved source not decoded as none");
   a_rx_inputs: assert property (@(posedge clock) disable iff (reset)
      (kind == GOM_KIND_RX && ctrl_bus.signal_select == SEL_1 && ctrl_bus.drive_enable)
      |=> pin3_out == $past(rx_remote_input[{rx_index, 2'h1}]))
      else $error("rx remote input 1 not routed");
   a_rx_inputs_hi: assert property (@(posedge clock) disable iff (reset)
      (kind == GOM_KIND_RX && ctrl_bus.signal_select == SEL_3 && ctrl_bus.drive_enable)
      |=> pin3_out == $past(rx_remote_input[{rx_index, 2'h3}]))
      else $error("rx remote input 3 not routed");
   a_rx_lock: assert property (@(posedge clock) disable iff (reset)
      (kind == GOM_KIND_RX && ctrl_bus.signal_select == SEL_4 && ctrl_bus.drive_enable)
      |=> pin3_out == $past(rx_lock[rx_index]))
      else $error("rx lock not routed");
   a_dev_local: assert property (@(posedge clock) disable iff (reset)
      s_dev_local |=> pin3_out == $past(ctrl_bus.local_value))
      else $error("local value not on pin");
   a_dev_lock_or: assert property (@(posedge clock) disable iff (reset)
      (kind == GOM_KIND_DEV && ctrl_bus.signal_select == SEL_1 && ctrl_bus.drive_enable)
      |=> pin3_out == $past(|(rx_lock & rx_port_enabled)))
      else $error("device lock or wrong");
   a_dev_reserved: assert property (@(posedge clock) disable iff (reset)
      (kind == GOM_KIND_DEV && ctrl_bus.signal_select > SEL_4) |=> !pin3_out)
      else $error("device reserved select not low");
   a_dev_pass_and: assert property (@(posedge clock) disable iff (reset)
      (kind == GOM_KIND_DEV && ctrl_bus.signal_select == SEL_3 && ctrl_bus.drive_enable)
      |=> pin3_out == $past(&(rx_pass | ~rx_port_enabled)))
      else $error("device pass and wrong");
   a_tx_pass_or: assert property (@(posedge clock) disable iff (reset)
      (kind == GOM_KIND_TX && ctrl_bus.signal_select == SEL_1 && ctrl_bus.drive_enable)
      |=> pin3_out == $past(|(rx_pass & tx_port_select[tx_index*NUM_RX +: NUM_RX])))
      else $error("tx pass or wrong");
   a_tx_line: assert property (@(posedge clock) disable iff (reset)
      (kind == GOM_KIND_TX && ctrl_bus.signal_select == SEL_3 && ctrl_bus.drive_enable)
      |=> pin3_out == $past(tx_line_valid[tx_index]))
      else $error("tx line valid not routed");
   a_tx_sync: assert property (@(posedge clock) disable iff (reset)
      (kind == GOM_KIND_TX && ctrl_bus.signal_select == SEL_4 && ctrl_bus.drive_enable)
      |=> pin3_out == $past(tx_synchronized[tx_index]))
      else $error("tx synchronized not routed");
   a_tx_irq: assert property (@(posedge clock) disable iff (reset)
      (kind == GOM_KIND_TX && ctrl_bus.signal_select == SEL_5 && ctrl_bus.drive_enable)
      |=> pin3_out == $past(tx_interrupt[tx_index]))
      else $error("tx interrupt not routed");
   a_drive_gate: assert property (@(posedge clock) disable iff (reset)
      !ctrl_bus.drive_enable |=> !pin3_oe && !pin3_out)
      else $error("pin driven while disabled");
   a_drive_on: assert property (@(posedge clock) disable iff (reset)
      ctrl_bus.drive_enable |=> pin3_oe)
      else $error("pin not driven while enabled");
   a_reserved_low: assert property (@(posedge clock) disable iff (reset)
      (kind == GOM_KIND_NONE || (kind == GOM_KIND_TX && ctrl_bus.signal_select >= SEL_6)) |=> !pin3_out)
      else $error("reserved selection not low");
endmodule

// [design/gom_pkg.sv]
// package: register map, field layout and selector codes of the pin 3 output multiplexer
package gom_pkg;
   localparam int unsigned NUM_RX = 4;
   localparam int unsigned NUM_TX = 2;
   localparam logic [7:0] CTRL_OFFSET = 8'h13;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam int unsigned SEL_MSB = 7;
   localparam int unsigned SEL_LSB = 5;
   localparam int unsigned SRC_MSB = 4;
   localparam int unsigned SRC_LSB = 2;
   localparam int unsigned VAL_BIT = 1;
   localparam int unsigned EN_BIT = 0;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   // source codes
   localparam logic [2:0] SRC_RX0 = 3'h0;
   localparam logic [2:0] SRC_RX3 = 3'h3;
   localparam logic [2:0] SRC_DEV = 3'h4;
   localparam logic [2:0] SRC_RSVD = 3'h5;
   localparam logic [2:0] SRC_TX0 = 3'h6;
   localparam logic [2:0] SRC_TX1 = 3'h7;
   // signal select codes
   localparam logic [2:0] SEL_0 = 3'h0;
   localparam logic [2:0] SEL_1 = 3'h1;
   localparam logic [2:0] SEL_2 = 3'h2;
   localparam logic [2:0] SEL_3 = 3'h3;
   localparam logic [2:0] SEL_4 = 3'h4;
   localparam logic [2:0] SEL_5 = 3'h5;
   localparam logic [2:0] SEL_6 = 3'h6;
   localparam logic [2:0] SEL_7 = 3'h7;
   typedef enum logic [1:0] {
      GOM_KIND_RX,
      GOM_KIND_DEV,
      GOM_KIND_TX,
      GOM_KIND_NONE
   } gom_kind_type;
endpackage

// [design/gom_src_decode.sv]
// module: decodes the source field into a source kind and port index
`timescale 1ns/1ps
module gom_src_decode
   import gom_pkg::*;
(
   gom_ctrl_if.consumer ctrl,
   output gom_kind_type kind,
   output logic [1:0] rx_index,
   output logic tx_index
);
   // source code map; 101 falls to the none kind
   always_comb begin
      kind = GOM_KIND_NONE;
      rx_index = ctrl.source_select[1:0];
      tx_index = ctrl.source_select[0];
      if (ctrl.source_select <= SRC_RX3) begin
         kind = GOM_KIND_RX;
      end else if (ctrl.source_select == SRC_DEV) begin
         kind = GOM_KIND_DEV;
      end else if (ctrl.source_select == SRC_TX0 || ctrl.source_select == SRC_TX1) begin
         kind = GOM_KIND_TX;
      end
   end
endmodule

// [verif/gom_pin3_mux_bench.sv]
// testbench: register port, signal selection and driver control of pin 3
`timescale 1ns/1ps
module gom_pin3_mux_bench;
   import gom_pkg::*;
   typedef struct packed {
      logic [7:0] ctrl;
      logic [52:0] stat;
      logic pin;
   } gom_row_type;
   logic clock = 1'b0;
   logic reset;
   logic [7:0] bus_addr, bus_wdata, bus_rdata;
   logic bus_write, bus_read, pin3_out, pin3_oe, pin_level;
   logic [52:0] stat;
   int n_mismatch = 0;
   int cmp_count = 0;
   // control byte, status bundle, expected pad level
   gom_row_type rows [32] = '{
      '{8'h01, 53'h1, 1'b1}, '{8'h25, 53'h20, 1'b1},
      '{8'h49, 53'h400, 1'b1}, '{8'h6d, 53'h8000, 1'b1},
      '{8'h89, 53'h4_0000, 1'b1}, '{8'ha5, 53'h20_0000, 1'b1},
      '{8'hcd, 53'h800_0000, 1'b1}, '{8'he1, 53'h1000_0000, 1'b1},
      '{8'h01, 53'h10, 1'b0}, '{8'h13, 53'h0, 1'b1},
      '{8'h11, 53'h0, 1'b0}, '{8'h31, 53'h4_0004_0000, 1'b1},
      '{8'h31, 53'h4_0002_0000, 1'b0}, '{8'h51, 53'h3_0030_0000, 1'b1},
      '{8'h71, 53'h3_0010_0000, 1'b0}, '{8'h71, 53'h3_0030_0000, 1'b1},
      '{8'h91, 53'h10_0000_0000, 1'b1}, '{8'hb1, 53'h10_0000_0000, 1'b0},
      '{8'hf1, 53'h10_0000_0000, 1'b0}, '{8'h17, 53'h10_0000_0000, 1'b0},
      '{8'h19, 53'h60_0030_0000, 1'b1}, '{8'h19, 53'h60_0010_0000, 1'b0},
      '{8'h3d, 53'h1000_0080_0000, 1'b1}, '{8'h3d, 53'h1000_0010_0000, 1'b0},
      '{8'h59, 53'h2000_0000_0000, 1'b1}, '{8'h5d, 53'h2000_0000_0000, 1'b0},
      '{8'h7d, 53'h1_0000_0000_0000, 1'b1}, '{8'h99, 53'h2_0000_0000_0000, 1'b1},
      '{8'hbd, 53'h10_0000_0000_0000, 1'b1}, '{8'hd9, 53'h2000_0000_0000, 1'b0},
      '{8'hfd, 53'h10_0000_0000_0000, 1'b0}, '{8'h12, 53'h0, 1'b0}
   };
   gom_pin3_mux uut (
      .clock(clock), .reset(reset), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata),
      .rx_remote_input(stat[15:0]), .rx_lock(stat[19:16]), .rx_pass(stat[23:20]),
      .rx_frame_valid(stat[27:24]), .rx_line_valid(stat[31:28]), .rx_port_enabled(stat[35:32]),
      .frame_sync_pulse(stat[36]), .tx_port_select(stat[44:37]), .tx_frame_valid(stat[46:45]),
      .tx_line_valid(stat[48:47]), .tx_synchronized(stat[50:49]), .tx_interrupt(stat[52:51]),
      .pin3_in(pin_level), .pin3_out(pin3_out), .pin3_oe(pin3_oe)
   );
   gom_pin_observer far_end (.clock(clock), .pin3_out(pin3_out), .pin3_oe(pin3_oe), .pin_level(pin_level));
   // 100 MHz clock
   always #5 clock = ~clock;
   // compare and count; four-state so an unknown never matches
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      cmp_count++;
      if (seen !== want) begin
         n_mismatch++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask
   // one bus cycle, launched just after a rising edge
   task automatic bus_op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      bus_write <= w;
      bus_read <= r;
      bus_addr <= a;
      bus_wdata <= d;
   endtask
   // register back at zero and pad released
   task automatic check_cleared;
      bus_op(1'b0, 1'b1, CTRL_OFFSET, 8'h00);
      bus_op(1'b0, 1'b0, 8'h00, 8'h00);
      #1;
      check(bus_rdata, CTRL_RESET);
      check({6'h0, pin3_oe, pin3_out}, 8'h00);
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // watchdog: the whole run needs about 124 cycles
   initial begin
      #20000;
      n_mismatch++;
      stop_test();
   end
   // main sequence
   initial begin
      reset = 1'b1;
      bus_addr = 8'h00;
      bus_wdata = 8'h00;
      bus_write = 1'b0;
      bus_read = 1'b0;
      stat = '0;
      repeat (10) @(posedge clock);
      reset <= 1'b0;
      check_cleared();
      // table: write, read straight back, then look at the pad
      foreach (rows[i]) begin
         bus_op(1'b1, 1'b0, CTRL_OFFSET, rows[i].ctrl);
         stat <= rows[i].stat;
         bus_op(1'b0, 1'b1, CTRL_OFFSET, 8'h00);
         bus_op(1'b0, 1'b0, 8'h00, 8'h00);
         #1;
         check(bus_rdata, rows[i].ctrl);
         check({6'h0, pin3_oe, pin3_out}, {6'h0, rows[i].ctrl[EN_BIT], rows[i].pin});
         if (rows[i].ctrl[EN_BIT]) check({7'h0, pin_level}, {7'h0, rows[i].pin});
      end
      // status change alone moves the pad one edge later
      bus_op(1'b1, 1'b0, CTRL_OFFSET, 8'h89);
      bus_op(1'b0, 1'b0, 8'h00, 8'h00);
      for (int k = 0; k < 2; k++) begin
         @(posedge clock);
         stat <= (k == 0) ? 53'h4_0000 : 53'h0;
         @(posedge clock);
         #1;
         check({7'h0, pin3_out}, (k == 0) ? 8'h01 : 8'h00);
      end
      // unmapped neighbour: write ignored, read gives zero, back-to-back reads
      bus_op(1'b1, 1'b0, 8'h12, 8'hff);
      bus_op(1'b0, 1'b1, 8'h12, 8'h00);
      bus_op(1'b0, 1'b1, CTRL_OFFSET, 8'h00);
      #1;
      check(bus_rdata, READ_UNMAPPED);
      bus_op(1'b0, 1'b0, 8'h00, 8'h00);
      #1;
      check(bus_rdata, 8'h89);
      // read data stand for one cycle only, then fall back to zero
      @(posedge clock);
      #1;
      check(bus_rdata, 8'h00);
      // reset in mid-run while the selected source is high; pad must drop at the first reset edge
      @(posedge clock);
      reset <= 1'b1;
      stat <= 53'h4_0000;
      @(posedge clock);
      #1;
      check({6'h0, pin3_oe, pin3_out}, 8'h00);
      @(posedge clock);
      reset <= 1'b0;
      check_cleared();
      stop_test();
   end
endmodule

// [verif/gom_pin_observer.sv]
// far-side model: logic that samples the pin 3 pad level
`timescale 1ns/1ps
module gom_pin_observer (
   input wire logic clock,
   input wire logic pin3_out,
   input wire logic pin3_oe,
   output logic pin_level
);
   logic last_r = 1'b0;
   // remember the last driven level
   always_ff @(posedge clock) begin
      if (pin3_oe) last_r <= pin3_out;
   end
   // no pull on this pad: a released pad shows the inverse, so a stale value cannot pass
   assign pin_level = pin3_oe ? pin3_out : ~last_r;
endmodule
